// >>> src/dma_two_channel.sv
// Two-channel DMA engine with its APB register file.
// Assumes a single memory/I/O bus port; each byte is a read then a write.
`timescale 1ns/1ps
module dma_two_channel
   import dma_regs_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [APB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [1:0]            external_request_n,
   input  wire logic                  serial0_rx_ready,
   input  wire logic                  serial_tx_ready,
   output logic                       bus_req,
   output logic      [19:0]           bus_addr,
   output logic                       bus_io,
   output logic                       bus_write,
   output logic      [7:0]            bus_wdata,
   input  wire logic [7:0]            bus_rdata,
   output logic      [1:0]            request_served
);
   typedef struct packed {
      logic [19:0] chan0_source_pointer;
      logic [19:0] chan0_dest_pointer;
      logic [15:0] chan0_byte_count;
      logic [19:0] chan1_memory_pointer;
      logic [15:0] chan1_io_pointer;
      logic [15:0] chan1_byte_count;
      logic [7:0]  mode;
      logic [7:0]  wait_request_control;
      logic [1:0]  enable;
      xfer_state_t st;
      logic        chan;
      logic [1:0]  wcnt;
      logic [7:0]  data;
      logic        req;
      logic [19:0] addr;
      logic        io;
      logic        wr;
      logic [1:0]  served;
      logic [31:0] rdata;
      logic        err;
   } dma_state_t;

   dma_state_t  s_reg;
   dma_state_t  s_next;
   logic [9:0]  widx;
   logic        setup;
   logic        wr_acc;
   logic [1:0]  source_step_mode;
   logic [1:0]  dest_step_mode;
   logic        burst_select;
   logic [1:0]  memory_wait_count;
   logic [1:0]  io_wait_count;
   logic [1:0]  request_sense_select;
   logic [1:0]  chan1_direction_mode;
   logic        src_io;
   logic        dst_io;
   logic [1:0]  req_source;
   logic        ch0_req;
   logic [1:0]  ext_active;
   logic        ch0_go;
   logic        ch1_go;
   logic        pick;
   logic [19:0] rd_addr;
   logic [19:0] wr_addr;
   logic        rd_io;
   logic        wr_io;
   logic [1:0]  rd_wait;
   logic [1:0]  wr_wait;
   logic [19:0] src_step;
   logic [19:0] dst_step;
   logic [19:0] mem1_step;
   logic [7:0]  rd8;
   logic        hit;

   assign widx   = paddr[11:2];
   assign setup  = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;

   assign source_step_mode     = s_reg.mode[MODE_SM_LSB +: 2];
   assign dest_step_mode       = s_reg.mode[MODE_DM_LSB +: 2];
   assign burst_select         = s_reg.mode[MODE_BURST_BIT];
   assign memory_wait_count    = s_reg.wait_request_control[CTL_MWI_LSB +: 2];
   assign io_wait_count        = s_reg.wait_request_control[CTL_IWI_LSB +: 2];
   assign request_sense_select = s_reg.wait_request_control[CTL_DMS_LSB +: 2];
   assign chan1_direction_mode = s_reg.wait_request_control[CTL_DIM_LSB +: 2];

   assign src_io = (source_step_mode == STEP_IO);
   assign dst_io = (dest_step_mode == STEP_IO);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_req
         request_detect u_det (
            .clk        (clk),
            .resetn     (resetn),
            .request_n  (external_request_n[gi]),
            .edge_sense (request_sense_select[gi]),
            .clear      (s_reg.served[gi]),
            .active     (ext_active[gi])
         );
      end
   endgenerate

   // Memory-to-memory needs no request; the I/O side's bank bits pick one
   assign req_source = src_io ? s_reg.chan0_source_pointer[17:16]
                              : s_reg.chan0_dest_pointer[17:16];

   always_comb begin
      ch0_req = 1'b1;
      if (src_io | dst_io) begin
         case (req_source)
            REQ_PIN: ch0_req = ext_active[0];        // [R03]
            REQ_RX:  ch0_req = serial0_rx_ready;     // [R03]
            REQ_TX:  ch0_req = serial_tx_ready;      // [R03]
            default: ch0_req = 1'b0;                 // [R03]
         endcase
      end
   end

   // A zero count never starts a transfer
   assign ch0_go = s_reg.enable[0] & ch0_req & (s_reg.chan0_byte_count != 16'h0000);   // [R10]
   assign ch1_go = s_reg.enable[1] & ext_active[1] & (s_reg.chan1_byte_count != 16'h0000);

   addr_step #(.W(20)) u_src_step (
      .addr (s_reg.chan0_source_pointer),
      .mode (source_step_mode),
      .next (src_step)
   );
   addr_step #(.W(20)) u_dst_step (
      .addr (s_reg.chan0_dest_pointer),
      .mode (dest_step_mode),
      .next (dst_step)
   );
   addr_step #(.W(20)) u_mem1_step (
      .addr (s_reg.chan1_memory_pointer),
      .mode ({1'b0, chan1_direction_mode[0]}),
      .next (mem1_step)
   );

   // Channel 0 wins arbitration; channel 1 waits for an idle engine
   always_comb begin
      pick = s_reg.chan;
      if (s_reg.st == ST_IDLE) begin
         pick = ~ch0_go;
      end
      if (!pick) begin
         rd_addr = s_reg.chan0_source_pointer;
         rd_io   = src_io;
         wr_addr = s_reg.chan0_dest_pointer;
         wr_io   = dst_io;
      end else if (!chan1_direction_mode[1]) begin
         rd_addr = s_reg.chan1_memory_pointer;                // [R09]
         rd_io   = 1'b0;
         wr_addr = {4'h0, s_reg.chan1_io_pointer};            // [R09]
         wr_io   = 1'b1;
      end else begin
         rd_addr = {4'h0, s_reg.chan1_io_pointer};            // [R09]
         rd_io   = 1'b1;
         wr_addr = s_reg.chan1_memory_pointer;                // [R09]
         wr_io   = 1'b0;
      end
   end

   assign rd_wait = rd_io ? io_wait_count : memory_wait_count;   // [R07]
   assign wr_wait = wr_io ? io_wait_count : memory_wait_count;   // [R07]

   always_comb begin
      s_next        = s_reg;
      s_next.served = 2'h0;
      case (s_reg.st)
         ST_IDLE: begin
            if (ch0_go | ch1_go) begin
               s_next.chan = pick;
               s_next.addr = rd_addr;
               s_next.io   = rd_io;
               s_next.wr   = 1'b0;
               s_next.req  = 1'b1;
               s_next.wcnt = rd_wait;
               s_next.st   = ST_READ;
            end
         end
         ST_READ: begin
            if (s_reg.wcnt != 2'h0) begin
               s_next.wcnt = s_reg.wcnt - 1'b1;   // [R07]
            end else begin
               s_next.data = bus_rdata;
               s_next.addr = wr_addr;
               s_next.io   = wr_io;
               s_next.wr   = 1'b1;
               s_next.wcnt = wr_wait;
               s_next.st   = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (s_reg.wcnt != 2'h0) begin
               s_next.wcnt = s_reg.wcnt - 1'b1;   // [R07]
            end else begin
               s_next.req          = 1'b0;
               s_next.wr           = 1'b0;
               s_next.served[pick] = 1'b1;
               if (!pick) begin
                  s_next.chan0_source_pointer = src_step;   // [R06]
                  s_next.chan0_dest_pointer   = dst_step;   // [R06]
                  s_next.chan0_byte_count     = s_reg.chan0_byte_count - 16'h0001;   // [R10]
                  if (s_reg.chan0_byte_count == 16'h0001) begin
                     s_next.enable[0] = 1'b0;   // [R10]
                  end
                  // Cycle steal hands one idle cycle back to the processor
                  s_next.st = burst_select ? ST_IDLE : ST_GAP;   // [R06]
               end else begin
                  s_next.chan1_memory_pointer = mem1_step;   // [R09]
                  s_next.chan1_byte_count     = s_reg.chan1_byte_count - 16'h0001;   // [R10]
                  if (s_reg.chan1_byte_count == 16'h0001) begin
                     s_next.enable[1] = 1'b0;   // [R10]
                  end
                  s_next.st = ST_GAP;
               end
            end
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase

      // Register file; a software write overrides the engine's update
      rd8 = 8'h00;
      hit = 1'b1;
      if (widx == IDX_SRC_LOW) begin
         rd8 = s_reg.chan0_source_pointer[7:0];
         if (wr_acc) s_next.chan0_source_pointer[7:0] = pwdata[7:0];   // [R01]
      end else if (widx == IDX_SRC_MID) begin
         rd8 = s_reg.chan0_source_pointer[15:8];
         if (wr_acc) s_next.chan0_source_pointer[15:8] = pwdata[7:0];   // [R01]
      end else if (widx == IDX_SRC_BANK) begin
         rd8 = {4'h0, s_reg.chan0_source_pointer[19:16]};
         if (wr_acc) s_next.chan0_source_pointer[19:16] = pwdata[3:0];   // [R01]
      end else if (widx == IDX_DST_LOW) begin
         rd8 = s_reg.chan0_dest_pointer[7:0];
         if (wr_acc) s_next.chan0_dest_pointer[7:0] = pwdata[7:0];   // [R02]
      end else if (widx == IDX_DST_MID) begin
         rd8 = s_reg.chan0_dest_pointer[15:8];
         if (wr_acc) s_next.chan0_dest_pointer[15:8] = pwdata[7:0];   // [R02]
      end else if (widx == IDX_DST_BANK) begin
         rd8 = {4'h0, s_reg.chan0_dest_pointer[19:16]};
         if (wr_acc) s_next.chan0_dest_pointer[19:16] = pwdata[3:0];   // [R02]
      end else if (widx == IDX_CNT0_LOW) begin
         rd8 = s_reg.chan0_byte_count[7:0];
         if (wr_acc) s_next.chan0_byte_count[7:0] = pwdata[7:0];
      end else if (widx == IDX_CNT0_HIGH) begin
         rd8 = s_reg.chan0_byte_count[15:8];
         if (wr_acc) s_next.chan0_byte_count[15:8] = pwdata[7:0];
      end else if (widx == IDX_MEM1_LOW) begin
         rd8 = s_reg.chan1_memory_pointer[7:0];
         if (wr_acc) s_next.chan1_memory_pointer[7:0] = pwdata[7:0];   // [R04]
      end else if (widx == IDX_MEM1_MID) begin
         rd8 = s_reg.chan1_memory_pointer[15:8];
         if (wr_acc) s_next.chan1_memory_pointer[15:8] = pwdata[7:0];   // [R04]
      end else if (widx == IDX_MEM1_BANK) begin
         rd8 = {4'h0, s_reg.chan1_memory_pointer[19:16]};
         if (wr_acc) s_next.chan1_memory_pointer[19:16] = pwdata[3:0];   // [R04]
      end else if (widx == IDX_IO1_LOW) begin
         rd8 = s_reg.chan1_io_pointer[7:0];
         if (wr_acc) s_next.chan1_io_pointer[7:0] = pwdata[7:0];   // [R04]
      end else if (widx == IDX_IO1_HIGH) begin
         rd8 = s_reg.chan1_io_pointer[15:8];
         if (wr_acc) s_next.chan1_io_pointer[15:8] = pwdata[7:0];   // [R04]
      end else if (widx == IDX_CNT1_LOW) begin
         rd8 = s_reg.chan1_byte_count[7:0];
         if (wr_acc) s_next.chan1_byte_count[7:0] = pwdata[7:0];   // [R05]
      end else if (widx == IDX_CNT1_HIGH) begin
         rd8 = s_reg.chan1_byte_count[15:8];
         if (wr_acc) s_next.chan1_byte_count[15:8] = pwdata[7:0];   // [R05]
      end else if (widx == IDX_ENABLE) begin
         rd8 = {3'h0, s_reg.st != ST_IDLE, 2'h0, s_reg.enable};
         if (wr_acc) s_next.enable = pwdata[1:0];
      end else if (widx == IDX_MODE) begin
         rd8 = s_reg.mode;
         if (wr_acc) s_next.mode = pwdata[7:0];   // [R06]
      end else if (widx == IDX_CONTROL) begin
         rd8 = s_reg.wait_request_control;
         if (wr_acc) s_next.wait_request_control = pwdata[7:0];   // [R07] [R08] [R09]
      end else begin
         hit = 1'b0;
      end
      // Read data is caught in the setup cycle so the access needs no wait
      if (setup) begin
         s_next.rdata = {24'h000000, rd8};
         s_next.err   = ~hit;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg                      <= '0;
         s_reg.wait_request_control <= CTL_RESET;   // [R07]
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata         = s_reg.rdata;
   assign pready         = 1'b1;
   assign pslverr        = s_reg.err & psel & penable;
   assign bus_req        = s_reg.req;
   assign bus_addr       = s_reg.addr;
   assign bus_io         = s_reg.io;
   assign bus_write      = s_reg.wr;
   assign bus_wdata      = s_reg.data;
   assign request_served = s_reg.served;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic ch0_end;
   assign ch0_end = (s_reg.st == ST_WRITE) && (s_reg.wcnt == 2'h0) && !s_reg.chan && !wr_acc;

   sequence read_three_waits;
      (s_reg.st == ST_READ) [*4];
   endsequence
   sequence then_write;
      (s_reg.st == ST_WRITE) && s_reg.wr;
   endsequence

   AST_SRC_LOW_WRITE: assert property ( // [R01]
      (wr_acc && widx == IDX_SRC_LOW) |=> s_reg.chan0_source_pointer[7:0] == $past(pwdata[7:0]))
      else $error("source low byte not written");
   AST_DST_BANK_READ: assert property ( // [R02]
      (setup && !pwrite && widx == IDX_DST_BANK) |=>
         prdata == {28'h0, $past(s_reg.chan0_dest_pointer[19:16])})
      else $error("destination bank read wrong");
   AST_TX_GATES_START: assert property ( // [R03]
      (s_reg.st == ST_IDLE && (src_io || dst_io) && req_source == REQ_TX && !serial_tx_ready)
         |=> !(s_reg.st == ST_READ && !s_reg.chan))
      else $error("channel 0 started without transmit request");
   AST_SRC_STEP_UP: assert property ( // [R06]
      (ch0_end && source_step_mode == STEP_INC)
         |=> s_reg.chan0_source_pointer == $past(s_reg.chan0_source_pointer) + 20'h00001)
      else $error("source pointer did not increment");
   AST_CYCLE_STEAL_GAP: assert property ( // [R06]
      (ch0_end && !burst_select) |=> s_reg.st == ST_GAP ##1 s_reg.st == ST_IDLE)
      else $error("cycle steal gap missing");
   AST_COUNT_DOWN: assert property ( // [R10]
      ch0_end |=> s_reg.chan0_byte_count == $past(s_reg.chan0_byte_count) - 16'h0001)
      else $error("channel 0 count not decremented");
   AST_ZERO_STOPS: assert property ( // [R10]
      (s_reg.st == ST_IDLE && s_reg.chan0_byte_count == 16'h0000)
         |=> !(s_reg.st == ST_READ && !s_reg.chan))
      else $error("transfer started at zero count");
   AST_WAIT_THREE: assert property ( // [R07]
      ($rose(s_reg.req) && s_reg.wcnt == 2'h3) |-> read_three_waits ##1 then_write)
      else $error("read phase length wrong for three waits");
   AST_CH1_IO_TO_MEM: assert property ( // [R09]
      (s_reg.st == ST_IDLE && ch1_go && !ch0_go && chan1_direction_mode[1])
         |=> s_reg.io && s_reg.addr == {4'h0, $past(s_reg.chan1_io_pointer)})
      else $error("channel 1 did not read I/O first");
endmodule

// >>> src/dma_regs_pkg.sv
// Constants, encodings and register indices for the two-channel DMA block.
// Assumes a 10 MHz system clock and an APB master with a 12-bit byte address.
// Functional notes
// [R01] Channel 0 source address is 20 bits in low, middle and bank bytes.
// [R02] Channel 0 destination address is 20 bits in low, middle and bank bytes.
// [R03] I/O-side bank bits 17:16 pick channel 0 request: pin, receive, transmit, none.
// [R04] Channel 1 keeps a 20-bit memory address and a separate I/O address.
// [R05] Channel 1 keeps a 16-bit byte count; high byte holds bits 15 to 8.
// [R06] Step modes: increment, decrement, fixed memory, fixed I/O; burst or cycle steal.
// [R07] Control holds memory and I/O wait counts 0..3; resets to 0xf0.
// [R08] Per-channel sense bit: 1 detects request pin by edge, 0 by level.
// [R09] Channel 1 direction: memory to I/O or I/O to memory, memory steps up or down.
// [R10] Each byte decrements the count; transfers stop when the count reaches zero.
// [R11] An external requester holds its request until its transfer is done.
package dma_regs_pkg;
   localparam int          APB_ADDR_W     = 12;
   // Word indices; the byte address is four times the index
   localparam logic [9:0]  IDX_SRC_LOW    = 10'h020;
   localparam logic [9:0]  IDX_SRC_MID    = 10'h021;
   localparam logic [9:0]  IDX_SRC_BANK   = 10'h022;
   localparam logic [9:0]  IDX_DST_LOW    = 10'h023;
   localparam logic [9:0]  IDX_DST_MID    = 10'h024;
   localparam logic [9:0]  IDX_DST_BANK   = 10'h025;
   localparam logic [9:0]  IDX_CNT0_LOW   = 10'h026;
   localparam logic [9:0]  IDX_CNT0_HIGH  = 10'h027;
   localparam logic [9:0]  IDX_MEM1_LOW   = 10'h028;
   localparam logic [9:0]  IDX_MEM1_MID   = 10'h029;
   localparam logic [9:0]  IDX_MEM1_BANK  = 10'h02a;
   localparam logic [9:0]  IDX_IO1_LOW    = 10'h02b;
   localparam logic [9:0]  IDX_IO1_HIGH   = 10'h02c;
   localparam logic [9:0]  IDX_CNT1_LOW   = 10'h02e;
   localparam logic [9:0]  IDX_CNT1_HIGH  = 10'h02f;
   localparam logic [9:0]  IDX_ENABLE     = 10'h030;
   localparam logic [9:0]  IDX_MODE       = 10'h031;
   localparam logic [9:0]  IDX_CONTROL    = 10'h032;
   // Field positions
   localparam int          MODE_DM_LSB    = 4;
   localparam int          MODE_SM_LSB    = 2;
   localparam int          MODE_BURST_BIT = 1;
   localparam int          CTL_MWI_LSB    = 6;
   localparam int          CTL_IWI_LSB    = 4;
   localparam int          CTL_DMS_LSB    = 2;
   localparam int          CTL_DIM_LSB    = 0;
   localparam int          EN_BUSY_BIT    = 4;
   // Values after reset
   localparam logic [7:0]  CTL_RESET      = 8'hf0;
   localparam logic [3:0]  DETECT_RESET   = 4'he;
   // Step modes and channel 0 request sources
   localparam logic [1:0]  STEP_INC       = 2'h0;
   localparam logic [1:0]  STEP_DEC       = 2'h1;
   localparam logic [1:0]  STEP_FIX       = 2'h2;
   localparam logic [1:0]  STEP_IO        = 2'h3;
   localparam logic [1:0]  REQ_PIN        = 2'h0;
   localparam logic [1:0]  REQ_RX         = 2'h1;
   localparam logic [1:0]  REQ_TX         = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b11,
      ST_GAP   = 2'b10
   } xfer_state_t;
endpackage

// >>> src/addr_step.sv
// Next-address computation for one DMA pointer.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module addr_step
   import dma_regs_pkg::*;
#(
   parameter int W = 20
) (
   input  wire logic [W-1:0] addr,
   input  wire logic [1:0]   mode,
   output logic [W-1:0]      next
);
   always_comb begin
      case (mode)
         STEP_INC: next = addr + 1'b1;   // [R06]
         STEP_DEC: next = addr - 1'b1;   // [R06]
         default:  next = addr;          // [R06]
      endcase
   end
endmodule

// >>> src/request_detect.sv
// Synchroniser and level/edge detector for one active-low request pin.
// The pin is asynchronous to clk; clear comes from the engine on clk.
`timescale 1ns/1ps
module request_detect
   import dma_regs_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic request_n,
   input  wire logic edge_sense,
   input  wire logic clear,
   output logic      active
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
      logic pending;
   } detect_state_t;
   detect_state_t r_reg;
   detect_state_t r_next;
   logic          fall;

   assign fall = r_reg.prev & ~r_reg.s2;

   always_comb begin
      r_next         = r_reg;
      r_next.s1      = request_n;
      r_next.s2      = r_reg.s1;
      r_next.prev    = r_reg.s2;
      // A new edge in the clearing cycle is kept
      r_next.pending = fall | (r_reg.pending & ~clear);   // [R08]
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= DETECT_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   // Level sense trusts the requester to hold the pin until served
   // The served pulse masks the edge it clears, so a burst restart cannot reuse it
   assign active = edge_sense ? (r_reg.pending & ~clear) : ~r_reg.s2;   // [R08] [R11]

   AST_EDGE_PENDING: assert property (@(posedge clk) disable iff (!resetn) // [R08]
      (edge_sense && fall) |=> r_reg.pending && (active || clear))
      else $error("edge not latched as pending");
endmodule

// >>> bench/mem_io_model.sv
// Memory and I/O space that answers the DMA engine's read phases.
// Assumes the engine holds address and direction steady for a whole phase.
`timescale 1ns/1ps
module mem_io_model (
   input  wire logic        clk,
   input  wire logic        bus_req,
   input  wire logic [19:0] bus_addr,
   input  wire logic        bus_io,
   input  wire logic        bus_write,
   output logic      [7:0]  bus_rdata
);
   logic [7:0] last;

   always_ff @(posedge clk) last <= bus_rdata;

   // Data is a fixed function of the place; outside a read the inverse of the
   // last value shows, so a late sample cannot pass by luck
   always_comb begin
      if (bus_req && !bus_write) bus_rdata = bus_addr[7:0] ^ bus_addr[15:8] ^ {7'h0, bus_io};
      else bus_rdata = ~last;
   end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the two-channel DMA block: registers over APB, bus traffic.
// Assumes a zero-wait APB slave and one read/write byte pair per transfer.
`timescale 1ns/1ps
module testbench;
   import dma_regs_pkg::*;
   logic        clk, resetn, psel, penable, pwrite, pready, pslverr, srx, stx, pw;
   logic        bus_req, bus_io, bus_write;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  req_n, served;
   logic [19:0] bus_addr, s, d, m1;
   logic [15:0] io1;
   logic [7:0]  bus_wdata, bus_rdata, v;
   logic [32:0] rq[$];
   logic [28:0] wq[$];
   int          fails, n_checks, seed;
   int          cyc = 0;
   logic [9:0]  regs[13] = '{IDX_SRC_LOW, IDX_SRC_MID, IDX_SRC_BANK, IDX_DST_LOW, IDX_DST_MID,
      IDX_DST_BANK, IDX_CNT0_HIGH, IDX_MEM1_MID, IDX_MEM1_BANK, IDX_IO1_HIGH, IDX_CNT1_HIGH,
      IDX_MODE, IDX_CONTROL};

   dma_two_channel u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_request_n(req_n), .serial0_rx_ready(srx),
      .serial_tx_ready(stx), .bus_req(bus_req), .bus_addr(bus_addr), .bus_io(bus_io),
      .bus_write(bus_write), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .request_served(served));
   mem_io_model u_mem (.clk(clk), .bus_req(bus_req), .bus_addr(bus_addr), .bus_io(bus_io),
      .bus_write(bus_write), .bus_rdata(bus_rdata));

   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end

   task automatic bad(input string m);
      fails++;
      $display("[ERR] %0t %s", $time, m);
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic logic [19:0] stp(input logic [19:0] a, input logic [1:0] md, input int b);
      return md == STEP_INC ? a + 20'(b) : md == STEP_DEC ? a - 20'(b) : a;
   endfunction

   task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] dat);
      @(posedge clk);
      psel    <= 1;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'($random(seed)), dat};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel    <= 0;
      penable <= 0;
   endtask

   task automatic rd(input logic [9:0] idx, input logic [32:0] e);
      rq.push_back(e);
      apb(0, idx, 8'h00);
   endtask

   task automatic wr3(input logic [9:0] idx, input logic [19:0] a);
      apb(1, idx, a[7:0]);
      apb(1, idx + 10'h1, a[15:8]);
      apb(1, idx + 10'h2, {4'h0, a[19:16]});
   endtask

   // Expected engine write, carrying what the model gives at the read place
   task automatic xp(input logic [19:0] wa, input logic wio, input logic [19:0] ra,
                     input logic rio);
      wq.push_back({wa, wio, ra[7:0] ^ ra[15:8] ^ {7'h0, rio}});
   endtask

   task automatic wsv(input int n);
      int k = 0;
      repeat (400) begin
         @(posedge clk);
         if (served !== 2'b00) k++;
         if (k == n) break;
      end
      n_checks++;
      if (k != n) bad("transfer did not complete");
   endtask

   always @(posedge clk) begin
      pw <= bus_write;
      if (psel && penable && pready && !pwrite) begin
         n_checks++;
         if (rq.size() == 0 || {pslverr, prdata} !== rq.pop_front()) bad("read mismatch");
      end
      if (bus_write && !pw) begin
         n_checks++;
         if (wq.size() == 0 || {bus_addr, bus_io, bus_wdata} !== wq.pop_front()) begin
            bad("bus write mismatch");
         end
      end
      cyc++;
      if (cyc == 20000) begin
         bad("timeout");
         conclude;
      end
   end

   initial begin
      {psel, penable, pwrite, srx, stx} = '0;
      paddr = '0;
      pwdata = '0;
      req_n = 2'b11;
      resetn = 0;
      seed = 38;
      fails = 0;
      n_checks = 0;
      repeat (4) @(posedge clk);
      resetn <= 1;
      rd(IDX_CONTROL, {25'h0, CTL_RESET});
      rd(IDX_DST_BANK, 33'h0);
      apb(1, 10'h03f, 8'h5a);
      rd(10'h03f, {1'b1, 32'h0});
      foreach (regs[i]) begin
         v = 8'($random(seed));
         apb(1, regs[i], v);
         rd(regs[i], {25'h0, regs[i] inside {IDX_SRC_BANK, IDX_DST_BANK, IDX_MEM1_BANK}
            ? v & 8'h0f : v});
      end
      for (int m = 0; m < 3; m++) begin
         s = 20'($random(seed));
         d = 20'($random(seed));
         wr3(IDX_SRC_LOW, s);
         wr3(IDX_DST_LOW, d);
         apb(1, IDX_CNT0_LOW, 8'h02);
         apb(1, IDX_CNT0_HIGH, 8'h00);
         apb(1, IDX_CONTROL, {4'($random(seed)), 4'h0});
         apb(1, IDX_MODE, {2'b00, 2'((m + 1) % 3), 2'(m), 1'(m), 1'b0});
         for (int b = 0; b < 2; b++) xp(stp(d, 2'((m + 1) % 3), b), 0, stp(s, 2'(m), b), 0);
         apb(1, IDX_ENABLE, 8'h01);
         wsv(2);
         rd(IDX_CNT0_LOW, 33'h0);
         rd(IDX_ENABLE, 33'h0);
         rd(IDX_SRC_LOW, {25'h0, 8'(stp(s, 2'(m), 2))});
      end
      apb(1, IDX_CONTROL, 8'h00);
      for (int r = 0; r < 3; r++) begin
         s = {2'b00, 2'(r), 16'($random(seed))};
         d = {2'b00, 2'(r), 16'($random(seed))};
         wr3(IDX_SRC_LOW, s);
         wr3(IDX_DST_LOW, d);
         apb(1, IDX_CNT0_LOW, 8'h01);
         // The transmit case puts the I/O side on the destination
         apb(1, IDX_MODE, r == 2 ? {2'b00, STEP_IO, STEP_INC, 2'b00}
                                 : {4'h0, STEP_IO, 2'b00});
         xp(d, r == 2, s, r != 2);
         apb(1, IDX_ENABLE, 8'h01);
         repeat (8) @(posedge clk);
         n_checks++;
         if (bus_req !== 1'b0) bad("transfer without request");
         {stx, srx, req_n[0]} <= {r == 2, r == 1, r != 0};
         wsv(1);
         {stx, srx, req_n[0]} <= 3'b001;
      end
      m1 = 20'($random(seed));
      io1 = 16'($random(seed));
      apb(1, IDX_IO1_LOW, io1[7:0]);
      apb(1, IDX_IO1_HIGH, io1[15:8]);
      apb(1, IDX_CNT1_HIGH, 8'h00);
      for (int r = 0; r < 4; r++) begin
         wr3(IDX_MEM1_LOW, m1);
         apb(1, IDX_CNT1_LOW, 8'h02);
         apb(1, IDX_CONTROL, {4'($random(seed)), 2'b00, 2'(r)});
         for (int b = 0; b < 2; b++)
            if (r < 2) xp({4'h0, io1}, 1, stp(m1, 2'(r), b), 0);
            else xp(stp(m1, 2'(r - 2), b), 0, {4'h0, io1}, 1);
         apb(1, IDX_ENABLE, 8'h02);
         req_n[1] <= 0;
         wsv(2);
         req_n[1] <= 1;
      end
      apb(1, IDX_CNT1_LOW, 8'h02);
      apb(1, IDX_CONTROL, 8'h08);
      xp({4'h0, io1}, 1, stp(m1, STEP_DEC, 2), 0);
      apb(1, IDX_ENABLE, 8'h02);
      req_n[1] <= 0;
      wsv(1);
      repeat (30) @(posedge clk);
      n_checks++;
      if (bus_req !== 1'b0) bad("held edge served twice");
      rd(IDX_CNT1_LOW, 33'h1);
      req_n[1] <= 1;
      repeat (4) @(posedge clk);
      n_checks++;
      if (rq.size() + wq.size() != 0) bad("expected results never seen");
      conclude;
   end
endmodule
